// ---- verilog/madc_regs.vh ----
// Register map, field positions and constants of the monitor converter sequencer
`ifndef MADC_REGS_VH
`define MADC_REGS_VH

// Register offsets
`define MADC_RESULT_HIGH_ADDR     8'h07
`define MADC_RESULT_LOW_ADDR      8'h08
`define MADC_CONTROL_ADDR         8'h09
`define MADC_CHAN_STATUS_ADDR     8'h0A

// Control register fields
`define MADC_CTRL_ENABLE_BIT      0
`define MADC_CTRL_ONE_SHOT_BIT    1
`define MADC_CTRL_SCAN_BIT        2
`define MADC_CTRL_BUF_DIS_BIT     3
`define MADC_CTRL_RESET           8'h00

// Channel select and status fields
`define MADC_CONV_SEL_LSB         0
`define MADC_READ_SEL_LSB         3
`define MADC_READY_BIT            7
`define MADC_CHAN_RESET           8'h00
`define MADC_SEL_RESET            3'h0
`define MADC_RDATA_RESET          8'h00

// Channel codes
`define MADC_CH_OUT_CURRENT       3'h0
`define MADC_CH_OUT_VOLTAGE       3'h1
`define MADC_CH_IN_VOLTAGE        3'h2
`define MADC_CH_IN_CURRENT        3'h3
`define MADC_CH_UNUSED            3'h4
`define MADC_CH_DIE_TEMP          3'h5
`define MADC_CH_EXT_INPUT         3'h6
`define MADC_CH_LAST              3'h6

// Result slice placement
`define MADC_HIGH_MSB             11
`define MADC_HIGH_LSB             4
`define MADC_LOW_MSB              3
`define MADC_LOW_LSB              0

`endif

// ---- verilog/madc_sequencer.v ----
// Monitor converter sequencer: register file, single-shot and polling control
`timescale 1ns/1ps
`include "madc_regs.vh"

// Host register view:
//   0x07 selected result bits 11..4
//   0x08 selected result bits 3..0 in the upper nibble
//   0x09 enable, one-shot, scan and buffer disable in bits 0 to 3
//   0x0A conversion select, read select, ready flag in bit 7
// The analog converter sits outside: it answers each start pulse with
// a one-cycle done pulse and the raw code on the same cycle.
// Read select code 7 names no channel and reads zero.

module madc_sequencer #(
  parameter DATA_W = 12,                 // Converter resolution
  parameter NCHAN  = 7                   // Multiplexed channel count
) (
  input  wire              clk,
  input  wire              reset_n,
  input  wire              regWrite,     // One-cycle register write strobe
  input  wire              regRead,      // One-cycle register read strobe
  input  wire [7:0]        regAddr,
  input  wire [7:0]        regWdata,
  output reg  [7:0]        regRdata,     // Read data, valid cycle after regRead
  output reg               convStart,    // Pulse: start one conversion
  output reg  [2:0]        muxChannel,   // Analog input selection
  output reg               inputBufferDisable,
  input  wire              convDone,     // Pulse: conversion finished
  input  wire [DATA_W-1:0] convData,     // Raw code with convDone
  output reg               interrupt_out_n
);

  // Sequencer states
  localparam ST_IDLE = 2'b00;            // Waiting for enable
  localparam ST_CONV = 2'b01;            // Conversion in flight
  localparam ST_NEXT = 2'b10;            // Polling: advance channel

  // Per-channel result storage, indexed by channel code
  reg  [DATA_W-1:0] result [0:NCHAN-1];
  reg  [7:0]        control;             // Converter control register
  reg  [2:0]        conversionChannelSelect;
  reg  [2:0]        readChannelSelect;
  reg               dataReady;           // Sticky completion flag
  reg  [1:0]        state;
  // Control register fields
  wire              enable   = control[`MADC_CTRL_ENABLE_BIT];
  wire              oneShot  = control[`MADC_CTRL_ONE_SHOT_BIT];
  wire              scan     = control[`MADC_CTRL_SCAN_BIT];
  wire              isResult;
  wire [DATA_W-1:0] selected;            // Result picked by the read select
  wire              writeControl;        // Host write to control register
  wire              writeChannels;       // Host write to select register
  wire              lastChannel;         // Conversion in flight is the last code

  // Address is a result register
  function isResultAddr;
    input [7:0] a;
    begin
      isResultAddr = (a == `MADC_RESULT_HIGH_ADDR) || (a == `MADC_RESULT_LOW_ADDR);
    end
  endfunction

  assign isResult = regRead && isResultAddr(regAddr);

  // Write decodes shared by the register processes
  assign writeControl  = regWrite && (regAddr == `MADC_CONTROL_ADDR);
  assign writeChannels = regWrite && (regAddr == `MADC_CHAN_STATUS_ADDR);
  // Polling wraps back to channel zero after this code
  assign lastChannel   = (muxChannel == `MADC_CH_LAST);

  // Seven-to-one result selector; unused code 7 reads zero
  assign selected = (readChannelSelect <= `MADC_CH_LAST) ?
                    result[readChannelSelect] : {DATA_W{1'b0}};

  // Result storage, written only by completed conversions
  // Each slot loads only while its own channel is in flight
  genvar g;
  generate
    for (g = 0; g < NCHAN; g = g + 1)
    begin : gResult
      always @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          result[g] <= {DATA_W{1'b0}};
        else if (convDone && state == ST_CONV && muxChannel == g)
          result[g] <= convData;
      end
    end
  endgenerate

  // Register reads, selected result split over two registers
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdata <= `MADC_RDATA_RESET;
    else if (regRead)
    begin
      // Status read leaves the ready flag untouched
      case (regAddr)
        `MADC_RESULT_HIGH_ADDR: regRdata <= selected[`MADC_HIGH_MSB:`MADC_HIGH_LSB];
        `MADC_RESULT_LOW_ADDR:  regRdata <= {selected[`MADC_LOW_MSB:`MADC_LOW_LSB], 4'h0};
        `MADC_CONTROL_ADDR:     regRdata <= control;
        `MADC_CHAN_STATUS_ADDR: regRdata <= {dataReady, 1'b0, readChannelSelect,
                                             conversionChannelSelect};
        default:                regRdata <= 8'h00;  // Unmapped reads zero
      endcase
    end
  end

  // Channel select register, writable part
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      conversionChannelSelect <= `MADC_SEL_RESET;
      readChannelSelect       <= `MADC_SEL_RESET;
    end
    // Bits 7:6 are read-only: ready flag and a zero
    else if (writeChannels)
    begin
      conversionChannelSelect <= regWdata[`MADC_CONV_SEL_LSB +: 3];
      readChannelSelect       <= regWdata[`MADC_READ_SEL_LSB +: 3];
    end
  end

  // Sequencer: control register, enable self-clear, ready, interrupt
  // A completion and a result read may land in one cycle; the later
  // assignments below let the completion win so no result goes unseen.
  // Clearing enable in polling stops only after the running conversion.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      control            <= `MADC_CTRL_RESET;
      state              <= ST_IDLE;
      convStart          <= 1'b0;
      muxChannel         <= `MADC_CH_OUT_CURRENT;
      inputBufferDisable <= 1'b0;
      dataReady          <= 1'b0;
      interrupt_out_n    <= 1'b1;       // Idle high, nothing pending
    end
    else
    begin
      convStart <= 1'b0;
      inputBufferDisable <= control[`MADC_CTRL_BUF_DIS_BIT];
      // Result read releases interrupt and ready
      if (isResult)
      begin
        interrupt_out_n <= 1'b1;
        dataReady       <= 1'b0;
      end
      if (writeControl)
        control <= regWdata;
      case (state)
        ST_IDLE:
        begin
          if (enable && (oneShot || scan))
          begin
            muxChannel <= oneShot ? conversionChannelSelect : `MADC_CH_OUT_CURRENT;
            convStart  <= 1'b1;
            state      <= ST_CONV;
          end
          // Enable with neither mode bit set stays idle
        end
        ST_CONV:
        begin
          // No timeout: waits as long as the converter needs
          if (convDone)
          begin
            if (oneShot)
            begin
              // Completion wins over a same-cycle result read
              dataReady       <= 1'b1;
              interrupt_out_n <= 1'b0;
              control[`MADC_CTRL_ENABLE_BIT] <= 1'b0;
              state <= ST_IDLE;
            end
            else if (lastChannel)
            begin
              // Whole sweep done; no interrupt in polling
              dataReady <= 1'b1;
              state     <= ST_NEXT;
            end
            else
              state <= ST_NEXT;          // More channels left in this sweep
          end
        end
        ST_NEXT:
        begin
          // Continue while enabled, else stop after this channel
          if (enable && scan)
          begin
            muxChannel <= lastChannel ? `MADC_CH_OUT_CURRENT
                          : muxChannel + 3'h1;
            convStart  <= 1'b1;
            state      <= ST_CONV;
          end
          else
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule

// ---- verif/madc_sequencer_properties.sv ----
// Port-level properties of the monitor converter sequencer
`timescale 1ns/1ps
module madc_sequencer_properties #(
  parameter DATA_W = 12
) (
  input wire              clk,
  input wire              reset_n,
  input wire              regWrite,
  input wire              regRead,
  input wire [7:0]        regAddr,
  input wire [7:0]        regWdata,
  input wire [7:0]        regRdata,
  input wire              convStart,
  input wire [2:0]        muxChannel,
  input wire              inputBufferDisable,
  input wire              convDone,
  input wire [DATA_W-1:0] convData,
  input wire              interrupt_out_n
);
  reg              oneShot, pollOn;  // Mode shadows
  reg [2:0]        cSel, rSel, lCh;  // Selects, last converted channel
  reg [DATA_W-1:0] lData;            // Newest converter code
  wire             rdRes = regRead && (regAddr == 8'h07 || regAddr == 8'h08);
  // Shadow host writes and finished conversions
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {oneShot, pollOn, cSel, rSel, lCh} <= 11'h007;
      lData <= {DATA_W{1'b0}};
    end
    else
    begin
      if (regWrite && regAddr == 8'h09)
        {pollOn, oneShot} <= {regWdata[2] & regWdata[0] & ~regWdata[1], regWdata[1]};
      if (regWrite && regAddr == 8'h0A)
        {rSel, cSel} <= regWdata[5:0];
      if (convDone)
        {lCh, lData} <= {muxChannel, convData};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence resultRead;
    rdRes && rSel == lCh;
  endsequence
  start_pulse_a: assert property (convStart |=> !convStart)
    else $error("start pulse too long");
  shot_chan_a: assert property (convStart && oneShot |-> muxChannel == cSel)
    else $error("wrong channel started");
  irq_cause_a: assert property ($fell(interrupt_out_n) |-> oneShot && $past(convDone))
    else $error("interrupt without completion");
  irq_hold_a: assert property (!interrupt_out_n && !rdRes |=> !interrupt_out_n)
    else $error("interrupt dropped early");
  irq_release_a: assert property (rdRes && !convDone |=> interrupt_out_n)
    else $error("interrupt kept after read");
  poll_step_a: assert property (convDone && pollOn |-> ##2 (convStart && muxChannel ==
    (($past(muxChannel, 2) == 3'h6) ? 3'h0 : $past(muxChannel, 2) + 3'h1)))
    else $error("polling order broken");
  result_map_a: assert property (resultRead |=> regRdata == (($past(regAddr) == 8'h07) ?
    $past(lData[11:4]) : {$past(lData[3:0]), 4'h0}))
    else $error("result bits misplaced");
  buf_copy_a: assert property (regWrite && regAddr == 8'h09 |->
    ##2 inputBufferDisable == $past(regWdata[3], 2))
    else $error("buffer disable wrong");
endmodule
bind madc_sequencer madc_sequencer_properties #(.DATA_W(DATA_W)) props_u (.clk(clk),
  .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata), .convStart(convStart), .muxChannel(muxChannel),
  .inputBufferDisable(inputBufferDisable), .convDone(convDone), .convData(convData),
  .interrupt_out_n(interrupt_out_n));

// ---- verif/madc_conv_model.sv ----
// Converter stand-in answering each start after a fixed time
`timescale 1ns/1ps
module madc_conv_model (
  input  wire        clk,
  input  wire        convStart,
  input  wire [2:0]  muxChannel,
  input  wire [3:0]  salt,
  output reg         convDone,
  output reg  [11:0] convData
);
  integer n = 0;  // Cycles left in flight
  initial {convDone, convData} = 13'h0000;
  // Count down, then pulse done; data toggles outside the pulse
  always @(posedge clk)
  begin
    convDone <= (n == 1);
    convData <= (n == 1) ? {salt, 1'b0, muxChannel, 4'h9} : ~convData;
    n <= (convStart === 1'b1) ? 5 : (n > 0 ? n - 1 : 0);
  end
endmodule

// ---- verif/madc_sequencer_bench.sv ----
// Self-checking bench of the monitor converter sequencer
`timescale 1ns/1ps
module madc_sequencer_bench;
  reg         clk = 0, reset_n = 0, regWrite = 0, regRead = 0;
  reg  [7:0]  regAddr = 0, regWdata = 0, rv;
  reg  [3:0]  salt = 0;
  wire [7:0]  regRdata;
  wire [2:0]  muxChannel;
  wire [11:0] convData;
  wire        convStart, convDone, inputBufferDisable, interrupt_out_n;
  integer     miscompares = 0, samples_checked = 0, i;
  reg  [11:0] starts = 0, snap = 0;  // Conversion start count, scenario snapshot
  always #5 clk = ~clk;
  // Count conversion starts seen on the converter link
  always @(posedge clk)
    if (convStart === 1'b1) starts <= starts + 12'h001;
  madc_sequencer dut_u (.clk(clk), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .convStart(convStart),
    .muxChannel(muxChannel), .inputBufferDisable(inputBufferDisable), .convDone(convDone),
    .convData(convData), .interrupt_out_n(interrupt_out_n));
  madc_conv_model conv_u (.clk(clk), .convStart(convStart), .muxChannel(muxChannel),
    .salt(salt), .convDone(convDone), .convData(convData));
  task cmp(input [63:0] nm, input [11:0] e, input [11:0] g);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge clk) {regWrite, regAddr, regWdata} = {1'b1, a, d};
    @(negedge clk) regWrite = 0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(negedge clk) {regRead, regAddr} = {1'b1, a};
    @(negedge clk) regRead = 0;
    rv = regRdata;
  end
  endtask
  task wait_ready;
  begin
    rv = 0;
    repeat (60) if (!rv[7]) rd(8'h0A);
    cmp("ready", 1, rv[7]);
  end
  endtask
  task t_oneshot;
  begin
    for (i = 0; i < 7; i = i + 1)
    begin
      wr(8'h0A, {2'b00, i[2:0], i[2:0]});
      wr(8'h09, 8'h03);
      repeat (20) if (interrupt_out_n) @(negedge clk);
      cmp("irq", 0, interrupt_out_n);
      rd(8'h09);
      cmp("ctrl", 8'h02, rv);
      rd(8'h0A);
      cmp("status", {2'b10, i[2:0], i[2:0]}, rv);
      rd(8'h07);
      cmp("high", {salt, 1'b0, i[2:0]}, rv);
      cmp("irqoff", 1, interrupt_out_n);
      rd(8'h08);
      cmp("low", 8'h90, rv);
    end
  end
  endtask
  task t_poll;
  begin
    salt = 4'hC;
    wr(8'h09, 8'h05);
    rd(8'h07);
    wait_ready;
    rd(8'h07);
    wait_ready;
    for (i = 0; i < 7; i = i + 1)
    begin
      wr(8'h0A, {2'b00, i[2:0], 3'h0});
      rd(8'h07);
      cmp("poll", {salt, 1'b0, i[2:0]}, rv);
      cmp("noirq", 1, interrupt_out_n);
    end
    @(posedge convStart) wr(8'h09, 8'h04);
    repeat (12) @(negedge clk);
    rd(8'h09);
    cmp("ctrl", 8'h04, rv);
  end
  endtask
  task t_reset;
  begin
    rd(8'h09);
    cmp("ctrl0", 0, rv);
    cmp("irq0", 1, interrupt_out_n);
  end
  endtask
  task t_regs;
  begin
    snap = starts;
    wr(8'h09, 8'h08);
    repeat (2) @(negedge clk);
    cmp("bufdis", 1, inputBufferDisable);
    rd(8'h09);
    cmp("ctrl", 8'h08, rv);
    wr(8'h0A, 8'h2D);
    wr(8'h07, 8'hFF);
    rd(8'h07);
    cmp("keep", 8'hC5, rv);
    wr(8'h0A, 8'h38);
    rd(8'h07);
    cmp("sel7", 0, rv);
    rd(8'h00);
    cmp("unmap", 0, rv);
    wr(8'h09, 8'h00);
    repeat (2) @(negedge clk);
    cmp("bufdis", 0, inputBufferDisable);
    cmp("starts", 0, starts - snap);
  end
  endtask
  task end_sim;
  begin
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    reset_n = 1;
    t_reset;
    t_oneshot;
    t_poll;
    t_regs;
    end_sim;
  end
  initial
  begin
    #20000 miscompares = miscompares + 1;
    end_sim;
  end
endmodule
